// File: hw/dmd_top.sv
// Dual modulus divider control: main and swallow counters, modulus select
// output, counter and status latches.
// Assumes the serial programming front end supplies the shift register
// contents, a validity flag and stop or repeated start strobes, all
// synchronous to clk, and that the divider input is sampled on clk.
`include "dmd_regs.svh"

module dmd_top #(
  parameter int MAIN_W = `DMD_MAIN_W,
  parameter int SWAL_W = `DMD_SWAL_W
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // Divider input from the prescaler
  input  wire logic                     divider_clock_input,
  // Programming front end
  input  wire logic [MAIN_W-1:0]        shift_main,
  input  wire logic [SWAL_W-1:0]        shift_swallow,
  input  wire logic [`DMD_STATUS_W-1:0] shift_status,
  input  wire dmd_pkg::dmd_msg_t        shift_kind,
  input  wire logic                     msg_valid,
  input  wire logic                     stop_seen,
  input  wire logic                     restart_seen,
  // Outputs
  output logic                          prescaler_ratio_select,
  output logic                          divided_pulse,
  output logic                          doubler_enable,
  output logic [`DMD_STATUS_W-1:0]      status_latch,
  output logic                          dual_mode
);

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  if (MAIN_W != `DMD_MAIN_W || SWAL_W != `DMD_SWAL_W) begin : g_width_check
    $error("dmd_top: counter widths must match the latch layout");
  end

  localparam int SC_W = SWAL_W + 1;

  dmd_pkg::dmd_state_t state;
  dmd_pkg::dmd_state_t next_state;

  logic [MAIN_W-1:0] main_count;
  logic              main_zero;
  logic [SC_W-1:0]   swal_count;
  logic              swal_zero;
  logic              fi_edge;
  logic              expire;
  logic              transfer;
  logic [SC_W-1:0]   swal_reload;
  logic              swal_step;

  // ---------------------------------------------------------------------------
  // Division timing
  // ---------------------------------------------------------------------------
  assign fi_edge = divider_clock_input && !state.fi_prev;                  // [R11]
  // A count of one expires on the next edge, so N edges make one cycle.
  assign expire  = fi_edge && (main_zero || main_count == MAIN_W'(1));     // [R2]
  // Zero must not end the swallow phase at once; it stands for a full count.
  assign swal_reload = (state.swal_latch == '0) ? `DMD_SWAL_ZERO_COUNT    // [R7]
                                                : {1'b0, state.swal_latch};
  assign swal_step   = fi_edge && state.dual_mode && !expire;              // [R1]

  dmd_down_counter #(
    .WIDTH (MAIN_W)
  ) u_main (
    .clk        (clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .load       (expire),                                                  // [R5]
    .load_value (state.main_latch),
    .step       (fi_edge),                                                 // [R11]
    .count      (main_count),
    .is_zero    (main_zero)
  );

  dmd_down_counter #(
    .WIDTH (SC_W)
  ) u_swallow (
    .clk        (clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .load       (expire && state.dual_mode),                               // [R5]
    .load_value (swal_reload),
    .step       (swal_step),
    .count      (swal_count),
    .is_zero    (swal_zero)
  );

  // ---------------------------------------------------------------------------
  // Latch transfer
  // ---------------------------------------------------------------------------
  // An invalid message is dropped whole, so a half-received channel never
  // reaches the counters.
  assign transfer = (stop_seen || restart_seen) && msg_valid;              // [R9] [R10]

  always_comb begin
    next_state           = state;
    next_state.fi_prev   = divider_clock_input;
    next_state.div_pulse = expire;                                         // [R2]
    if (transfer) begin
      unique case (shift_kind)
        dmd_pkg::DMD_MSG_MAIN_SINGLE: begin
          next_state.main_latch = shift_main;
          next_state.dual_mode  = 1'b0;                                    // [R1]
        end
        dmd_pkg::DMD_MSG_DUAL: begin
          next_state.main_latch = shift_main;
          next_state.swal_latch = shift_swallow;
          next_state.dual_mode  = 1'b1;                                    // [R3]
        end
        dmd_pkg::DMD_MSG_STATUS: begin
          next_state.status = shift_status;                                // [R8]
        end
        dmd_pkg::DMD_MSG_OTHER: begin
          next_state.status = state.status;
        end
      endcase
    end
    // Select is low while swallowing and high once the swallow count is
    // spent, until the main counter reloads both.
    if (!state.dual_mode) begin
      next_state.ratio_sel = 1'b0;                                         // [R1]
    end else if (fi_edge) begin
      next_state.ratio_sel = !expire &&                                    // [R4] [R5]
                             (swal_zero || swal_count == SC_W'(1));        // [R6]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state            <= '0;
      state.main_latch <= `DMD_MAIN_RESET;
      state.swal_latch <= `DMD_SWAL_RESET;
      state.status     <= `DMD_STATUS_RESET;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prescaler_ratio_select = state.ratio_sel;                         // [R3]
  assign divided_pulse          = state.div_pulse;
  assign doubler_enable         = state.status[`DMD_STATUS_DOUBLER];       // [R8]
  assign status_latch           = state.status;
  assign dual_mode              = state.dual_mode;

endmodule

// File: hw/dmd_regs.svh
// Constants of the dual modulus divider control block: widths, field
// positions, reset values and the special swallow count.
// Assumes it is included by bare name before the package and modules.
//
// Summary of operation
// R1 - In single modulus mode the swallow counter is idle and the main counter alone divides.
// R2 - In single modulus mode one output pulse is made per programmed main count of input edges.
// R3 - In dual modulus mode the swallow counter drives the prescaler ratio select output.
// R4 - Ratio select is low while the swallow counter is non-zero and goes high once it is zero.
// R5 - Ratio select stays high until the main counter expires, and then both counters reload.
// R6 - Per division cycle the select asks one ratio for swallow cycles and the other for the rest.
// R7 - A programmed swallow value of zero counts as 128 cycles.
// R8 - Status bit 7 switches the voltage doubler, low for off and high for on.
// R9 - New values move from the shift register to the latches only on a stop or repeated start.
// R10 - Latches are not updated unless the whole programming message was checked as valid.
// R11 - The main counter is 12 bits, the swallow counter 7, both step on divider input rising edges. The swallow counter here is 8 bits, to hold 128.
`ifndef DMD_REGS_SVH
`define DMD_REGS_SVH

// -----------------------------------------------------------------------------
// Widths
// -----------------------------------------------------------------------------
`define DMD_MAIN_W            12
`define DMD_SWAL_W            7
`define DMD_STATUS_W          8

// -----------------------------------------------------------------------------
// Fields and values
// -----------------------------------------------------------------------------
`define DMD_STATUS_DOUBLER    7
`define DMD_STATUS_RESET      8'h00
`define DMD_MAIN_RESET        12'h000
`define DMD_SWAL_RESET        7'h00
`define DMD_SWAL_ZERO_COUNT   8'h80

`endif

// File: hw/dmd_pkg.sv
// Types shared by the dual modulus divider control modules.
// Assumes dmd_regs.svh is on the include path.
`include "dmd_regs.svh"

package dmd_pkg;

  // ---------------------------------------------------------------------------
  // Kind of a checked programming message
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DMD_MSG_MAIN_SINGLE = 2'h0,
    DMD_MSG_DUAL        = 2'h1,
    DMD_MSG_STATUS      = 2'h2,
    DMD_MSG_OTHER       = 2'h3
  } dmd_msg_t;

  // ---------------------------------------------------------------------------
  // State of the top module
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic                       fi_prev;
    logic                       dual_mode;
    logic [`DMD_MAIN_W-1:0]     main_latch;
    logic [`DMD_SWAL_W-1:0]     swal_latch;
    logic [`DMD_STATUS_W-1:0]   status;
    logic                       ratio_sel;
    logic                       div_pulse;
  } dmd_state_t;

endpackage

// File: hw/dmd_down_counter.sv
// Loadable down counter that steps on a strobe.
// Assumes all strobes are synchronous to clk and held only while ce is high.
module dmd_down_counter #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             step,
  // Status
  output logic      [WIDTH-1:0] count,
  output logic                  is_zero
);

  if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
    $error("dmd_down_counter: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] value;
  } dmd_cnt_state_t;

  dmd_cnt_state_t state;
  dmd_cnt_state_t next_state;

  always_comb begin
    next_state = state;
    if (load) begin
      next_state.value = load_value;
    end else if (step && state.value != '0) begin
      next_state.value = state.value - WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign count   = state.value;
  assign is_zero = (state.value == '0);

endmodule

// File: tb/dmd_top_checker.sv
// Concurrent checks on the divider control ports.
// Assumes it is bound to dmd_top and sees only that module's ports.
`include "dmd_regs.svh"

module dmd_top_checker #(
  parameter int MAIN_W = 12,
  parameter int SWAL_W = 7
) (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic                     ce,
  // Inputs of the block
  input wire logic                     divider_clock_input,
  input wire logic [MAIN_W-1:0]        shift_main,
  input wire logic [SWAL_W-1:0]        shift_swallow,
  input wire logic [`DMD_STATUS_W-1:0] shift_status,
  input wire dmd_pkg::dmd_msg_t        shift_kind,
  input wire logic                     msg_valid,
  input wire logic                     stop_seen,
  input wire logic                     restart_seen,
  // Outputs of the block
  input wire logic                     prescaler_ratio_select,
  input wire logic                     divided_pulse,
  input wire logic                     doubler_enable,
  input wire logic [`DMD_STATUS_W-1:0] status_latch,
  input wire logic                     dual_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic ld = ce && msg_valid && (stop_seen || restart_seen);

  AST_NO_LOAD: assert property (!ld |=> $stable(status_latch) && $stable(dual_mode))
    else $error("latch moved without a valid message");
  AST_STATUS_LOAD: assert property (ld && shift_kind == dmd_pkg::DMD_MSG_STATUS
    |=> status_latch == $past(shift_status)) else $error("status latch not loaded");
  AST_DOUBLER: assert property (doubler_enable == status_latch[`DMD_STATUS_DOUBLER])
    else $error("doubler enable differs from status bit");
  AST_DUAL_SET: assert property (ld && shift_kind == dmd_pkg::DMD_MSG_DUAL |=> dual_mode)
    else $error("dual mode not entered");
  AST_SINGLE_SET: assert property (ld && shift_kind == dmd_pkg::DMD_MSG_MAIN_SINGLE
    |=> !dual_mode) else $error("single mode not entered");
  AST_SINGLE_SEL: assert property (!dual_mode && !$past(dual_mode) |-> !prescaler_ratio_select)
    else $error("ratio select high in single mode");
  AST_SEL_ON_EDGE: assert property ($changed(prescaler_ratio_select) && dual_mode
    && $past(dual_mode) |-> $past(divider_clock_input) && !$past(divider_clock_input, 2))
    else $error("ratio select moved away from an input edge");
  AST_EXPIRY_SEL: assert property (divided_pulse |-> !prescaler_ratio_select)
    else $error("ratio select high at expiry");
  // A pulse frozen by a low ce stands on, so only a freshly made one is tied to an edge.
  AST_PULSE_ON_EDGE: assert property (divided_pulse && $past(ce)
    |-> $past(divider_clock_input) && !$past(divider_clock_input, 2))
    else $error("output pulse not after an input edge");
endmodule

bind dmd_top dmd_top_checker #(.MAIN_W(MAIN_W), .SWAL_W(SWAL_W)) i_dmd_top_checker (
  .clk(clk), .rst_n(rst_n), .ce(ce), .divider_clock_input(divider_clock_input),
  .shift_main(shift_main), .shift_swallow(shift_swallow), .shift_status(shift_status),
  .shift_kind(shift_kind), .msg_valid(msg_valid), .stop_seen(stop_seen),
  .restart_seen(restart_seen), .prescaler_ratio_select(prescaler_ratio_select),
  .divided_pulse(divided_pulse), .doubler_enable(doubler_enable),
  .status_latch(status_latch), .dual_mode(dual_mode));

// File: tb/dmd_prescaler_model.sv
// Behavioural two-ratio prescaler that makes the divider input.
// Assumes the bench clock; a high select picks ratio P, a low one P + 1.
module dmd_prescaler_model #(
  parameter int P = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Ratio select in, divided output back to the block
  input  wire logic prescaler_ratio_select,
  output logic      divider_clock_input
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt;
  logic wrap;
  // The ratio is judged at the end of a period, so a select that moves
  // just after an edge governs the period that edge starts.
  assign wrap = (cnt + 1) >= (prescaler_ratio_select ? P : P + 1);
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      divider_clock_input <= 1'b0;
    end else begin
      cnt <= wrap ? 0 : cnt + 1;
      divider_clock_input <= wrap;
    end
  end
endmodule

// File: tb/dmd_top_tb.sv
// Self-checking bench of the divider control block.
// Assumes the prescaler model at the divider input, ratios 2 and 3.
module dmd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 2;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              ce = 1'b1;
  logic [11:0]       smain = 12'h000;
  logic [6:0]        sswal = 7'h00;
  logic [7:0]        sstat = 8'h00;
  dmd_pkg::dmd_msg_t skind = dmd_pkg::DMD_MSG_OTHER;
  logic              valid = 1'b0;
  logic              stop = 1'b0;
  logic              rstart = 1'b0;
  logic              fi, sel, pulse, dbl, dual;
  logic [7:0]        stl;
  int                fail_count = 0;
  int                tests_run = 0;

  always #25 clk = ~clk;

  dmd_top i_dmd_top (.clk(clk), .rst_n(rst_n), .ce(ce), .divider_clock_input(fi),
    .shift_main(smain), .shift_swallow(sswal), .shift_status(sstat), .shift_kind(skind),
    .msg_valid(valid), .stop_seen(stop), .restart_seen(rstart),
    .prescaler_ratio_select(sel), .divided_pulse(pulse), .doubler_enable(dbl),
    .status_latch(stl), .dual_mode(dual));
  dmd_prescaler_model #(.P(P)) i_dmd_prescaler_model (.clk(clk), .rst_n(rst_n),
    .prescaler_ratio_select(sel), .divider_clock_input(fi));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("mismatches %0d of %0d checks", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic send(input dmd_pkg::dmd_msg_t k, input logic [11:0] n, input logic [6:0] a,
                      input logic [7:0] s, input logic v, input logic rs);
    @(negedge clk);
    {skind, smain, sswal, sstat, valid, stop, rstart} = {k, n, a, s, v, !rs, rs};
    @(negedge clk);
    {valid, stop, rstart} = 3'h0;
  endtask

  task automatic test_status;
    send(dmd_pkg::DMD_MSG_STATUS, 12'h000, 7'h00, 8'h80, 1'b1, 1'b0);
    check("doubler on", 1, dbl);
    check("status", 8'h80, stl);
    send(dmd_pkg::DMD_MSG_STATUS, 12'h000, 7'h00, 8'h7F, 1'b0, 1'b0);
    check("status unchecked", 8'h80, stl);
    send(dmd_pkg::DMD_MSG_OTHER, 12'h000, 7'h00, 8'h7F, 1'b1, 1'b1);
    check("status other", 8'h80, stl);
    send(dmd_pkg::DMD_MSG_STATUS, 12'h000, 7'h00, 8'h7F, 1'b1, 1'b1);
    check("doubler off", 0, dbl);
  endtask

  // A valid message offered while ce is low must leave every latch as it was.
  task automatic test_freeze;
    @(negedge clk);
    ce = 1'b0;
    send(dmd_pkg::DMD_MSG_STATUS, 12'h000, 7'h00, 8'h80, 1'b1, 1'b0);
    check("frozen status", 8'h7F, stl);
    @(negedge clk);
    ce = 1'b1;
    check("frozen doubler", 0, dbl);
    check("frozen mode", 0, dual);
  endtask

  // Counts the clocks of one whole division cycle, and those with select high,
  // after skipping two cycles, the first of them still running on the old counts.
  task automatic test_divide(input dmd_pkg::dmd_msg_t k, input logic [11:0] n,
                             input logic [6:0] a, input int per_exp, input int hi_exp);
    int per;
    int hi;
    per = 0;
    hi = 0;
    send(k, n, a, 8'h00, 1'b1, 1'b0);
    check("mode", k == dmd_pkg::DMD_MSG_DUAL, dual);
    repeat (2) begin
      do @(negedge clk); while (pulse !== 1'b1);
    end
    do begin
      @(negedge clk);
      per++;
      if (sel === 1'b1) hi++;
    end while (pulse !== 1'b1);
    check("period", per_exp, per);
    check("select high", hi_exp, hi);
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check("reset out", 0, {sel, pulse, dbl, dual, stl});
    test_status;
    test_freeze;
    test_divide(dmd_pkg::DMD_MSG_MAIN_SINGLE, 12'd5, 7'd3, 5 * (P + 1), 0);
    test_divide(dmd_pkg::DMD_MSG_MAIN_SINGLE, 12'd1, 7'd0, P + 1, 0);
    test_divide(dmd_pkg::DMD_MSG_DUAL, 12'd6, 7'd2, 2 * (P + 1) + 4 * P, 4 * P);
    test_divide(dmd_pkg::DMD_MSG_DUAL, 12'd130, 7'd0, 128 * (P + 1) + 2 * P, 2 * P);
    test_divide(dmd_pkg::DMD_MSG_DUAL, 12'd3, 7'd5, 3 * (P + 1), 0);
    give_verdict;
  end

  initial begin
    #(20000 * 50);
    fail_count++;
    give_verdict;
  end
endmodule
